/* hdl/csw_pkg.sv */
// Package: constants and types of the instruction execution block
package csw_pkg;
  // ----------------------------------------
  // Bus map
  // ----------------------------------------
  localparam int CSW_ADR_W = 12;
  localparam logic [11:0] CSW_OFS_CTRL = 12'h000;
  localparam logic [11:0] CSW_OFS_INSTR = 12'h004;
  localparam logic [11:0] CSW_OFS_STATUS = 12'h008;
  localparam logic [11:0] CSW_OFS_PC = 12'h00c;
  localparam logic [11:0] CSW_OFS_COUNTER = 12'h010;
  localparam int CSW_RF_SEL_BIT = 11;
  localparam int CSW_RF_DEPTH = 512;
  // ----------------------------------------
  // Register fields
  // ----------------------------------------
  localparam int CSW_CTRL_Z = 0;
  localparam int CSW_CTRL_C = 1;
  localparam int CSW_CTRL_SINGLE = 2;
  localparam int CSW_STAT_BUSY = 0;
  localparam int CSW_STAT_Z = 1;
  localparam int CSW_STAT_C = 2;
  localparam int CSW_STAT_WAIT = 3;
  localparam int CSW_STAT_PC = 16;
  // ----------------------------------------
  // Instruction word fields
  // ----------------------------------------
  localparam int CSW_OP_LSB = 26;
  localparam int CSW_ZWR_BIT = 25;
  localparam int CSW_CWR_BIT = 24;
  localparam int CSW_WR_BIT = 23;
  localparam int CSW_IMM_BIT = 22;
  localparam int CSW_COND_LSB = 18;
  localparam int CSW_DST_LSB = 9;
  localparam int CSW_SRC_LSB = 0;
  // ----------------------------------------
  // Opcodes
  // ----------------------------------------
  localparam logic [5:0] CSW_OP_ZSUM = 6'h26;
  localparam logic [5:0] CSW_OP_TEST = 6'h18;
  localparam logic [5:0] CSW_OP_JNZ = 6'h3a;
  localparam logic [5:0] CSW_OP_JZ = 6'h3b;
  localparam logic [5:0] CSW_OP_CWAIT = 6'h3e;
  localparam logic [5:0] CSW_OP_PEQ = 6'h3c;
  localparam logic [5:0] CSW_OP_PNE = 6'h3d;
  // ----------------------------------------
  // Cycle counts and reset values
  // ----------------------------------------
  localparam logic [3:0] CSW_CYC_BASE = 4'h4;
  localparam logic [3:0] CSW_CYC_SLOW = 4'h8;
  localparam logic [3:0] CSW_CYC_WAIT = 4'h5;
  localparam logic [8:0] CSW_RST_PC = 9'h000;
  localparam logic CSW_RST_FLAG = 1'b0;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    CSW_IDLE = 3'b001,
    CSW_EXEC = 3'b010,
    CSW_WAIT = 3'b100
  } csw_state_t;
endpackage : csw_pkg

/* hdl/csw_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module csw_sync #(
  parameter int WIDTH = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Pins and filtered value
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] agree;
  logic [WIDTH-1:0] out_d;

  // A bit moves only once stages two and three agree
  assign agree = ~(s2_q ^ s3_q);
  assign out_d = (s2_q & agree) | (pin_out & ~agree);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      pin_out <= '0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      pin_out <= out_d;
    end
  end
endmodule : csw_sync

/* hdl/csw_exec.sv */
// Execution unit for sum, test, test-jump and wait instructions
// Notes on behaviour
// - Zero set: subtract source, else add
// - Sum flags: zero, signed overflow; 4 clocks
// - Test ANDs operands, never writes back
// - Test flags: zero result, odd parity
// - Jump-if-nonzero branches on nonzero destination
// - Nonzero jump: 4 taken, 8 not
// - Test-jumps: zero flag, carry 0, no write
// - Jump-if-zero branches on zero destination
// - Zero jump: 4 taken, 8 not
// - Counter wait: match, add delta, 5+
// - Counter wait flags from sum; optional write
// - Pin-equal wait: masked port equals state
// - Pin-differ wait: masked port differs, 5+
// - Carry picks port; single-port uses first
// - Pin waits: zero flag masked, no write
// - Immediate bit picks 9-bit literal source
//
// The implementer's own choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/10ps
module csw_exec (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [csw_pkg::CSW_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Input ports
  input wire logic [31:0] input_port_first,
  input wire logic [31:0] input_port_second,
  // Status
  output logic busy
);
  import csw_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  csw_state_t state_q;
  logic [31:0] rf_q [CSW_RF_DEPTH];
  logic [31:0] system_counter;
  logic [31:0] instr_q;
  logic [8:0] pc_q;
  logic z_q;
  logic c_q;
  logic single_q;
  logic [3:0] left_q;
  logic [5:0] op_q;
  logic [8:0] dst_q;
  logic [31:0] d_q;
  logic [31:0] s_q;
  logic [31:0] res_q;
  logic zu_q;
  logic zn_q;
  logic cu_q;
  logic cn_q;
  logic rwr_q;
  logic zopt_q;
  logic copt_q;
  logic wr_q;
  logic jump_q;
  logic hit_q;
  logic [31:0] first_s;
  logic [31:0] second_s;

  // Pins are asynchronous to clk
  csw_sync #(.WIDTH(32)) u_sync_first (
    .clk(clk),
    .rst_b(rst_b),
    .pin_in(input_port_first),
    .pin_out(first_s)
  );
  csw_sync #(.WIDTH(32)) u_sync_second (
    .clk(clk),
    .rst_b(rst_b),
    .pin_in(input_port_second),
    .pin_out(second_s)
  );

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic req;
  logic wr;
  logic [31:0] wmask;
  logic sel_rf;
  logic [8:0] rf_idx;
  logic sel_ctrl;
  logic sel_instr;
  logic sel_stat;
  logic sel_pc;
  logic sel_ctr;
  logic idle_wr;
  logic take;
  logic [31:0] instr_w;
  logic [31:0] ctrl_w;
  logic [31:0] pc_w;
  logic [31:0] rf_w;
  logic [31:0] stat_w;
  logic [31:0] rdata;

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = req && wb_we_i;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign sel_rf = wb_adr_i[CSW_RF_SEL_BIT];
  assign rf_idx = wb_adr_i[10:2];
  assign sel_ctrl = wb_adr_i == CSW_OFS_CTRL;
  assign sel_instr = wb_adr_i == CSW_OFS_INSTR;
  assign sel_stat = wb_adr_i == CSW_OFS_STATUS;
  assign sel_pc = wb_adr_i == CSW_OFS_PC;
  assign sel_ctr = wb_adr_i == CSW_OFS_COUNTER;
  // Writes that change state are refused while busy
  assign idle_wr = wr && !busy;
  // No new instruction during a stall
  assign take = idle_wr && sel_instr;
  assign instr_w = (instr_q & ~wmask) | (wb_dat_i & wmask);
  assign ctrl_w = {29'h0, single_q, c_q, z_q};
  assign pc_w = {23'h0, pc_q};
  assign rf_w = (rf_q[rf_idx] & ~wmask) | (wb_dat_i & wmask);
  assign stat_w = {7'h0, pc_q, 12'h0, state_q == CSW_WAIT, c_q, z_q, busy};
  assign rdata = sel_rf ? rf_q[rf_idx] :
                 sel_ctrl ? ctrl_w :
                 sel_instr ? instr_q :
                 sel_stat ? stat_w :
                 sel_pc ? pc_w :
                 sel_ctr ? system_counter : 32'h0;

  // ----------------------------------------
  // Instruction decode
  // ----------------------------------------
  logic [5:0] op_f;
  logic [3:0] cond_f;
  logic [8:0] dst_f;
  logic [8:0] src_f;
  logic [31:0] d_val;
  logic [31:0] s_val;
  logic cond_ok;
  logic is_sum;
  logic is_test;
  logic is_jnz;
  logic is_jz;
  logic is_tj;
  logic is_wait;
  logic flag_op;

  // Field split of the instruction word
  assign op_f = instr_w[CSW_OP_LSB +: 6];
  assign cond_f = instr_w[CSW_COND_LSB +: 4];
  assign dst_f = instr_w[CSW_DST_LSB +: 9];
  assign src_f = instr_w[CSW_SRC_LSB +: 9];
  assign d_val = rf_q[dst_f];
  assign s_val = instr_w[CSW_IMM_BIT] ? {23'h0, src_f} : rf_q[src_f];
  // Condition bit indexed by the current carry and zero
  assign cond_ok = cond_f[{c_q, z_q}];
  assign is_sum = op_f == CSW_OP_ZSUM;
  assign is_test = op_f == CSW_OP_TEST;
  assign is_jnz = op_f == CSW_OP_JNZ;
  assign is_jz = op_f == CSW_OP_JZ;
  assign is_tj = is_jnz || is_jz;
  assign is_wait = (op_f == CSW_OP_CWAIT) || (op_f == CSW_OP_PEQ) || (op_f == CSW_OP_PNE);
  assign flag_op = cond_ok && (is_sum || is_test || is_tj);

  // ----------------------------------------
  // Results at issue
  // ----------------------------------------
  logic [31:0] neg_s;
  logic [31:0] sum_w;
  logic ovf_w;
  logic [31:0] and_w;
  logic dz;
  logic jump_w;
  logic zn_w;
  logic cn_w;
  logic [3:0] cyc_w;

  // Source sign follows the zero flag
  assign neg_s = z_q ? 32'h0 - s_val : s_val;
  assign sum_w = d_val + neg_s;
  assign ovf_w = (d_val[31] == neg_s[31]) && (sum_w[31] != d_val[31]);
  assign and_w = d_val & s_val;
  assign dz = d_val == 32'h0;
  assign jump_w = cond_ok && ((is_jnz && !dz) || (is_jz && dz));
  assign zn_w = is_sum ? sum_w == 32'h0 : is_test ? and_w == 32'h0 : dz;
  assign cn_w = is_sum ? ovf_w : is_test ? ^and_w : 1'b0;
  // Fall-through of a test-jump is slow
  assign cyc_w = (cond_ok && is_tj && !jump_w) ? CSW_CYC_SLOW : CSW_CYC_BASE;

  // ----------------------------------------
  // Wait evaluation
  // ----------------------------------------
  logic [31:0] port_w;
  logic [31:0] masked_w;
  logic pin_hit;
  logic ctr_hit;
  logic met;
  logic is_cwait_q;
  logic [32:0] csum_w;
  logic release_w;
  logic exec_done;
  logic finish;
  logic ex_we;
  logic [31:0] ex_wdata;

  // Carry selects the port unless single-port
  assign port_w = (c_q && !single_q) ? second_s : first_s;
  assign masked_w = port_w & s_q;
  assign pin_hit = (op_q == CSW_OP_PEQ) ? masked_w == d_q : masked_w != d_q;
  // Counter match; a match seen early is held
  assign ctr_hit = system_counter == d_q;
  assign is_cwait_q = op_q == CSW_OP_CWAIT;
  assign met = is_cwait_q ? (hit_q || ctr_hit) : pin_hit;
  // Target plus delta with carry out
  assign csum_w = {1'b0, d_q} + {1'b0, s_q};
  // Release checked every clock after the minimum
  assign release_w = (state_q == CSW_WAIT) && (left_q == 4'h1) && met;
  assign exec_done = (state_q == CSW_EXEC) && (left_q == 4'h1);
  assign finish = exec_done || release_w;
  // Sum writes back, and of the waits only the counter wait
  assign ex_we = (exec_done && rwr_q) || (release_w && is_cwait_q && wr_q);
  assign ex_wdata = exec_done ? res_q : csum_w[31:0];

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= CSW_IDLE;
      busy <= 1'b0;
      left_q <= 4'h0;
      hit_q <= 1'b0;
    end else begin
      unique case (state_q)
        CSW_IDLE: begin
          if (take) begin
            state_q <= (cond_ok && is_wait) ? CSW_WAIT : CSW_EXEC;
            left_q <= (cond_ok && is_wait) ? CSW_CYC_WAIT : cyc_w;
            busy <= 1'b1;
            hit_q <= 1'b0;
          end
        end
        CSW_EXEC: begin
          left_q <= left_q - 4'h1;
          if (exec_done) begin
            state_q <= CSW_IDLE;
            busy <= 1'b0;
          end
        end
        CSW_WAIT: begin
          hit_q <= hit_q || ctr_hit;
          if (left_q != 4'h1) begin
            left_q <= left_q - 4'h1;
          end
          if (release_w) begin
            state_q <= CSW_IDLE;
            busy <= 1'b0;
          end
        end
      endcase
    end
  end

  // Operands and pending results held for the instruction
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      instr_q <= 32'h0;
      op_q <= 6'h0;
      dst_q <= 9'h0;
      d_q <= 32'h0;
      s_q <= 32'h0;
      res_q <= 32'h0;
      {zu_q, zn_q, cu_q, cn_q, rwr_q} <= 5'h0;
      {zopt_q, copt_q, wr_q, jump_q} <= 4'h0;
    end else if (take) begin
      instr_q <= instr_w;
      op_q <= op_f;
      dst_q <= dst_f;
      d_q <= d_val;
      s_q <= s_val;
      res_q <= sum_w;
      zu_q <= flag_op && instr_w[CSW_ZWR_BIT];
      zn_q <= zn_w;
      cu_q <= flag_op && instr_w[CSW_CWR_BIT];
      cn_q <= cn_w;
      // Of the executed instructions only the sum writes, and only with write set
      rwr_q <= cond_ok && is_sum && instr_w[CSW_WR_BIT];
      zopt_q <= instr_w[CSW_ZWR_BIT];
      copt_q <= instr_w[CSW_CWR_BIT];
      wr_q <= instr_w[CSW_WR_BIT];
      jump_q <= jump_w;
    end
  end

  // Flags, program counter and options
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      z_q <= CSW_RST_FLAG;
      c_q <= CSW_RST_FLAG;
      single_q <= CSW_RST_FLAG;
      pc_q <= CSW_RST_PC;
    end else begin
      if (idle_wr && sel_ctrl && wb_sel_i[0]) begin
        z_q <= wb_dat_i[CSW_CTRL_Z];
        c_q <= wb_dat_i[CSW_CTRL_C];
        single_q <= wb_dat_i[CSW_CTRL_SINGLE];
      end
      if (idle_wr && sel_pc) begin
        pc_q <= (pc_q & ~wmask[8:0]) | (wb_dat_i[8:0] & wmask[8:0]);
      end
      // Zero and carry from issue-time results; at release waits set zero, and the counter wait also carry
      if (exec_done && zu_q) begin
        z_q <= zn_q;
      end
      if (exec_done && cu_q) begin
        c_q <= cn_q;
      end
      if (release_w && zopt_q) begin
        z_q <= is_cwait_q ? csum_w[31:0] == 32'h0 : masked_w == 32'h0;
      end
      if (release_w && copt_q && is_cwait_q) begin
        c_q <= csum_w[32];
      end
      if (finish) begin
        pc_q <= jump_q ? s_q[8:0] : pc_q + 9'h1;
      end
    end
  end

  // Register file has no reset; software loads it
  always_ff @(posedge clk) begin
    if (ex_we) begin
      rf_q[dst_q] <= ex_wdata;
    end else if (idle_wr && sel_rf) begin
      rf_q[rf_idx] <= rf_w;
    end
  end

  // Counter and bus answer; unmapped reads return zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      system_counter <= 32'h0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      system_counter <= system_counter + 32'h1;
      wb_ack_o <= req;
      if (req) begin
        wb_dat_o <= rdata;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  logic go_sum;
  logic go_tj;
  assign go_sum = take && is_sum && cond_ok;
  assign go_tj = take && is_tj && cond_ok;

  sequence s_busy4;
    busy [*4] ##1 !busy;
  endsequence
  sequence s_busy8;
    busy [*8] ##1 !busy;
  endsequence

  a_sum_value: assert property (go_sum && instr_w[CSW_WR_BIT] |->
    ##5 rf_q[dst_q] == $past(z_q ? d_val - s_val : d_val + s_val, 5))
    else $error("sum result wrong");
  a_sum_time: assert property (go_sum |=> s_busy4)
    else $error("sum not four clocks");
  a_test_nowrite: assert property (take && is_test |=> !ex_we [*4])
    else $error("test wrote a register");
  a_test_parity: assert property (take && is_test && cond_ok && instr_w[CSW_CWR_BIT] |->
    ##5 c_q == $past(^(d_val & s_val), 5))
    else $error("test parity wrong");
  a_jump_taken: assert property (go_tj && jump_w |=> s_busy4)
    else $error("taken jump not four clocks");
  a_jump_fall: assert property (go_tj && !jump_w |=> s_busy8)
    else $error("fall through not eight clocks");
  a_jz_target: assert property (take && is_jz && cond_ok && dz |->
    ##5 pc_q == $past(s_val[8:0], 5))
    else $error("zero jump target wrong");
  // Flags land when busy falls: four clocks taken, eight on fall-through
  a_jump_carry: assert property (go_tj && jump_w && instr_w[CSW_CWR_BIT] |-> ##5 !c_q)
    else $error("taken test-jump carry not zero");
  a_fall_carry: assert property (go_tj && !jump_w && instr_w[CSW_CWR_BIT] |-> ##9 !c_q)
    else $error("fall-through carry not zero");
  a_wait_min: assert property (take && is_wait && cond_ok |=> busy [*5])
    else $error("wait shorter than five");
  a_wait_hold: assert property (state_q == CSW_WAIT && !met |=> state_q == CSW_WAIT)
    else $error("wait left early");
  a_cnt_sum: assert property (release_w && is_cwait_q && wr_q |=>
    rf_q[dst_q] == $past(d_q + s_q))
    else $error("counter sum not written");
  a_pin_zero: assert property (release_w && !is_cwait_q && zopt_q |=>
    z_q == ($past(masked_w) == 32'h0))
    else $error("pin wait zero flag wrong");
endmodule : csw_exec

/* verification/tb.sv */
// Self-checking testbench for the instruction execution block
`timescale 1ns/10ps
module tb;
  import csw_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [CSW_ADR_W-1:0] wb_adr_i = '0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [31:0] input_port_first = 32'h0;
  logic [31:0] input_port_second = 32'h0;
  logic busy;
  int failures = 0;
  int tests_run = 0;
  int n;
  logic [31:0] rd;
  logic [31:0] tgt;

  always #2 clk = ~clk;

  csw_exec uut (.clk(clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .input_port_first(input_port_first),
    .input_port_second(input_port_second), .busy(busy));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: %0s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic hang(input string msg);
    failures++;
    $display("mismatch at %0t: %0s timed out", $time, msg);
    final_report();
  endtask : hang

  // Classic single cycle, held until ack is sampled
  task automatic bus(input logic we, input logic [11:0] adr, input logic [31:0] dat);
    int i;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hf;
    wb_dat_i <= dat;
    for (i = 0; i < 100; i++) begin
      @(posedge clk);
      if (wb_ack_o === 1'b1) break;
    end
    if (wb_ack_o !== 1'b1) hang("bus answer");
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : bus

  task automatic rdchk(input logic [11:0] adr, input logic [31:0] exp, input string msg);
    bus(1'b0, adr, 32'h0);
    check(rd, exp, msg);
  endtask : rdchk

  function automatic logic [11:0] rfa(input int k);
    return 12'h800 + 12'(k * 4);
  endfunction : rfa

  function automatic logic [31:0] iw(input logic [5:0] op, input logic [3:0] zcri,
                                     input logic [8:0] d, input logic [8:0] s);
    return {op, zcri, 4'hf, d, s};
  endfunction : iw

  // Busy counted from the cycle after the issuing edge
  task automatic finish(input int lo, input int hi, input logic z, input logic c,
                        input logic [8:0] p);
    n = 1;
    while (n < 3000) begin
      @(negedge clk);
      if (busy !== 1'b1) break;
      n++;
    end
    if (busy !== 1'b0) hang("instruction");
    check({31'h0, n >= lo && n <= hi}, 32'h1, "busy cycles");
    bus(1'b0, CSW_OFS_STATUS, 32'h0);
    check(rd & 32'h01ff0007, {7'h0, p, 13'h0, c, z, 1'b0}, "status");
  endtask : finish

  task automatic run(input logic [31:0] w, input int lo, input int hi, input logic z,
                     input logic c, input logic [8:0] p);
    bus(1'b1, CSW_OFS_INSTR, w);
    finish(lo, hi, z, c, p);
  endtask : run

  task automatic stalled();
    repeat (20) @(negedge clk);
    check({31'h0, busy}, 32'h1, "stall");
  endtask : stalled

  task automatic done(input string s);
    $display("test %0s ended, %0d mismatches so far", s, failures);
  endtask : done

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    rdchk(CSW_OFS_STATUS, 32'h0, "status after reset");
    rdchk(12'h100, 32'h0, "unmapped read");
    done("reset");
    bus(1'b1, rfa(1), 32'd10);
    bus(1'b1, rfa(2), 32'd3);
    bus(1'b1, CSW_OFS_CTRL, 32'h1);
    run(iw(CSW_OP_ZSUM, 4'b1110, 9'd1, 9'd2), 4, 4, 1'b0, 1'b0, 9'h001);
    rdchk(rfa(1), 32'd7, "negated sum");
    run(iw(CSW_OP_ZSUM, 4'b1110, 9'd1, 9'd2), 4, 4, 1'b0, 1'b0, 9'h002);
    rdchk(rfa(1), 32'd10, "plain sum");
    bus(1'b1, rfa(1), 32'h7fffffff);
    run(iw(CSW_OP_ZSUM, 4'b1111, 9'd1, 9'h001), 4, 4, 1'b0, 1'b1, 9'h003);
    rdchk(rfa(1), 32'h80000000, "overflow sum");
    bus(1'b1, rfa(1), 32'hfffffffd);
    run(iw(CSW_OP_ZSUM, 4'b1001, 9'd1, 9'h003), 4, 4, 1'b1, 1'b1, 9'h004);
    rdchk(rfa(1), 32'hfffffffd, "no result write");
    done("sum");
    bus(1'b1, rfa(3), 32'h0000000f);
    run(iw(CSW_OP_TEST, 4'b1111, 9'd3, 9'h007), 4, 4, 1'b0, 1'b1, 9'h005);
    run(iw(CSW_OP_TEST, 4'b1111, 9'd3, 9'h003), 4, 4, 1'b0, 1'b0, 9'h006);
    run(iw(CSW_OP_TEST, 4'b1111, 9'd3, 9'h030), 4, 4, 1'b1, 1'b0, 9'h007);
    rdchk(rfa(3), 32'h0000000f, "test writes nothing");
    done("test");
    bus(1'b1, rfa(4), 32'd5);
    bus(1'b1, rfa(5), 32'd0);
    bus(1'b1, CSW_OFS_CTRL, 32'h2);
    run(iw(CSW_OP_JNZ, 4'b1111, 9'd4, 9'h055), 4, 4, 1'b0, 1'b0, 9'h055);
    run(iw(CSW_OP_JNZ, 4'b1111, 9'd5, 9'h011), 8, 8, 1'b1, 1'b0, 9'h056);
    run(iw(CSW_OP_JZ, 4'b1011, 9'd5, 9'h0aa), 4, 4, 1'b1, 1'b0, 9'h0aa);
    bus(1'b1, CSW_OFS_CTRL, 32'h2);
    run(iw(CSW_OP_JZ, 4'b1111, 9'd4, 9'h0aa), 8, 8, 1'b0, 1'b0, 9'h0ab);
    rdchk(rfa(4), 32'd5, "jump tested nonzero");
    rdchk(rfa(5), 32'd0, "jump tested zero");
    done("jumps");
    bus(1'b0, CSW_OFS_COUNTER, 32'h0);
    tgt = rd + 32'd60;
    bus(1'b1, rfa(6), tgt);
    bus(1'b1, rfa(7), -tgt);
    run(iw(CSW_OP_CWAIT, 4'b1110, 9'd6, 9'd7), 20, 70, 1'b1, 1'b1, 9'h0ac);
    rdchk(rfa(6), 32'h0, "target plus delta");
    done("counter wait");
    bus(1'b1, CSW_OFS_CTRL, 32'h0);
    bus(1'b1, rfa(8), 32'd5);
    input_port_second <= 32'h5;
    bus(1'b1, CSW_OFS_INSTR, iw(CSW_OP_PEQ, 4'b1011, 9'd8, 9'h00f));
    stalled();
    // Intruding issue while stalled must be dropped
    bus(1'b1, CSW_OFS_INSTR, iw(CSW_OP_ZSUM, 4'b0011, 9'd8, 9'h001));
    input_port_first <= 32'hf5;
    finish(1, 100, 1'b0, 1'b0, 9'h0ad);
    rdchk(rfa(8), 32'd5, "pin wait writes nothing");
    bus(1'b1, CSW_OFS_CTRL, 32'h2);
    input_port_first <= 32'h0;
    bus(1'b1, CSW_OFS_INSTR, iw(CSW_OP_PNE, 4'b1001, 9'd8, 9'h00f));
    stalled();
    input_port_second <= 32'h0;
    finish(1, 100, 1'b1, 1'b1, 9'h0ae);
    bus(1'b1, CSW_OFS_CTRL, 32'h6);
    input_port_first <= 32'h5;
    run(iw(CSW_OP_PEQ, 4'b1001, 9'd8, 9'h00f), 5, 12, 1'b0, 1'b1, 9'h0af);
    done("pin waits");
    // Condition field: bit indexed by {carry, zero}; false means no flag or register change, but the PC still advances
    run({CSW_OP_ZSUM, 4'b1110, 4'h0, 9'd8, 9'd2}, 4, 4, 1'b0, 1'b1, 9'h0b0);
    rdchk(rfa(8), 32'd5, "condition false writes nothing");
    run({CSW_OP_ZSUM, 4'b1110, 4'b0100, 9'd8, 9'd2}, 4, 4, 1'b0, 1'b0, 9'h0b1);
    rdchk(rfa(8), 32'd8, "condition true sum");
    done("condition");
    final_report();
  end
endmodule : tb
